//--- rtl/ssp_pkg.sv
// package: shared types and constants of the synchronous memory port
package ssp_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int SPACES = 4;
  localparam int SPACE_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int LAT_W = 2;
  localparam int PHASE_W = 3;
  // divider codes for the divided forwarded clock
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;
  // clock source codes
  localparam logic CLK_FULL = 1'h0;
  localparam logic CLK_DIV = 1'h1;

  // per-space secondary control
  typedef struct packed {
    logic [LAT_W-1:0] read_latency_cycles;
    logic [LAT_W-1:0] write_latency_cycles;
    logic select_extend;
    logic strobe_function_select;
    logic clock_source_select;
  } ssp_sec_s;

  // one queued access
  typedef struct packed {
    logic wr;
    logic [SPACE_W-1:0] space;
    logic [BE_W-1:0] be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ssp_req_s;

  // registered pin image
  typedef struct packed {
    logic [SPACES-1:0] cs_n;
    logic [BE_W-1:0] be_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic sa_n;
    logic sb_n;
    logic sc_n;
  } ssp_pins_s;

  localparam ssp_pins_s PINS_RST = '{cs_n: 4'hF, be_n: 4'hF, addr: 20'h00000, dout: 32'h00000000,
                                     doe: 1'h0, sa_n: 1'h1, sb_n: 1'h1, sc_n: 1'h1};

  typedef enum logic {ST_IDLE, ST_ACC} ssp_st_e;
endpackage : ssp_pkg

//--- rtl/ssp_port.sv
// synchronous sram / fifo memory port with request queue
//
// Contract
// - each space uses its own secondary settings
// - read data captured rl+1 cycles after command
// - write data driven wl cycles after command
// - extend off: select drops after last command
// - extend on: select held while output enable
// - strobe function 0: address strobe, deselect cycles
// - strobe function 1: read enable, no deselect
// - per-space choice of full or divided clock
// - three shared strobes: ads/sre, soe, swe
// - read data captured on selected rising edge
// - pins change only on selected rising edge
// - divided clock is full-rate clock over 1, 2, 4
`timescale 1ns/10ps

// request queue, flip-flop storage
module ssp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);
  localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
  } ssp_fifo_s;

  ssp_fifo_s s;
  ssp_fifo_s next_s;
  logic push;
  logic pop;

  // count-based flags; equal pointers alone cannot tell full from empty
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];
  assign in_ready = s.rdy;

  // pointer wrap works for any depth, not only powers of two
  always_comb begin
    next_s = s;
    push = in_valid & s.rdy;
    pop = out_ready & out_valid;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == LAST_IDX) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == LAST_IDX) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.rdy = (next_s.cnt != FULL_CNT); // registered so ready is a clean flop
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule : ssp_fifo

// memory port controller
module ssp_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // per-space secondary control and divider
  input wire ssp_pkg::ssp_sec_s [ssp_pkg::SPACES-1:0] space_secondary_control,
  input wire logic [1:0] div_sel,
  // access requests
  input wire logic req_valid,
  output logic req_ready,
  input wire ssp_pkg::ssp_req_s req,
  // read results
  output logic rd_valid,
  output logic [ssp_pkg::DATA_W-1:0] rd_data,
  // memory pins
  output logic full_rate_mem_clock_out,
  output logic divided_mem_clock_out,
  output logic [ssp_pkg::SPACES-1:0] chip_select_n,
  output logic [ssp_pkg::BE_W-1:0] byte_lane_enable_n,
  output logic [ssp_pkg::ADDR_W-1:0] address_bus_out,
  output logic [ssp_pkg::DATA_W-1:0] memory_data_bus_o,
  output logic memory_data_bus_oe,
  input wire logic [ssp_pkg::DATA_W-1:0] memory_data_bus_i,
  output logic shared_strobe_a_n,
  output logic shared_strobe_b_n,
  output logic shared_strobe_c_n
);
  typedef struct packed {
    ssp_pkg::ssp_st_e st;
    logic [ssp_pkg::SPACE_W-1:0] sp;
    logic wr;
    logic [ssp_pkg::LAT_W-1:0] cnt;
    logic [ssp_pkg::PHASE_W-1:0] ph;
    logic full_clk;
    logic div_clk;
    ssp_pkg::ssp_pins_s pins;
    logic [ssp_pkg::DATA_W-1:0] d_s1;
    logic [ssp_pkg::DATA_W-1:0] d_s2;
    logic rdv;
    logic [ssp_pkg::DATA_W-1:0] rdd;
    logic [1:0] cap_dly;
  } ssp_port_s;

  ssp_port_s s;
  ssp_port_s next_s;
  logic q_valid;
  logic q_pop;
  ssp_pkg::ssp_req_s q_data;
  ssp_pkg::ssp_sec_s hd_cfg;
  ssp_pkg::ssp_sec_s cur_cfg;
  // tick strobes of the full-rate and divided clocks
  logic full_tick;
  logic div_tick;
  logic hd_tick;
  logic cur_tick;
  logic done;

  // pick the rising edge the space follows
  function automatic logic sel_tick(input logic src, input logic f_tick, input logic d_tick);
    sel_tick = (src == ssp_pkg::CLK_DIV) ? d_tick : f_tick;
  endfunction : sel_tick

  // launch the command cycle of one access
  function automatic ssp_port_s issue(input ssp_port_s si, input ssp_pkg::ssp_req_s r,
                                      input ssp_pkg::ssp_sec_s c);
    ssp_port_s so;
    so = si;
    so.st = ssp_pkg::ST_ACC;
    so.sp = r.space;
    so.wr = r.wr;
    so.pins.cs_n = ~(ssp_pkg::SPACES'(1) << r.space);
    so.pins.be_n = ~r.be;
    so.pins.addr = r.addr;
    so.pins.dout = r.data;
    so.pins.sa_n = 1'b0;
    so.pins.sb_n = r.wr;
    so.pins.sc_n = ~r.wr;
    // write latency 0 puts data out with the command itself
    so.pins.doe = r.wr && (c.write_latency_cycles == '0);
    if (r.wr) begin
      so.cnt = (c.write_latency_cycles == '0) ? '0 : c.write_latency_cycles - 1'b1;
    end else begin
      so.cnt = c.read_latency_cycles;
    end
    issue = so;
  endfunction : issue

  // the queue decouples the request side from the slower memory ticks
  ssp_fifo #(
    .W($bits(ssp_pkg::ssp_req_s)),
    .D(ssp_pkg::FIFO_DEPTH)
  ) u_queue (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_data)
  );

  // settings of the queued and of the running access
  // settings are read live, so they must not change mid-access
  assign hd_cfg = space_secondary_control[q_data.space];
  assign cur_cfg = space_secondary_control[s.sp];

  // pins straight from the state flops
  assign full_rate_mem_clock_out = s.full_clk;
  assign divided_mem_clock_out = s.div_clk;
  assign chip_select_n = s.pins.cs_n;
  assign byte_lane_enable_n = s.pins.be_n;
  assign address_bus_out = s.pins.addr;
  assign memory_data_bus_o = s.pins.dout;
  assign memory_data_bus_oe = s.pins.doe;
  assign shared_strobe_a_n = s.pins.sa_n;
  assign shared_strobe_b_n = s.pins.sb_n;
  assign shared_strobe_c_n = s.pins.sc_n;
  assign rd_valid = s.rdv;
  assign rd_data = s.rdd;

  // clocks, edge ticks and the access sequencer
  always_comb begin
    next_s = s;
    q_pop = 1'b0;
    done = 1'b0;
    next_s.rdv = 1'b0;
    next_s.d_s1 = memory_data_bus_i;
    next_s.d_s2 = s.d_s1;
    // the pin value at the capture tick leaves the synchroniser two cycles later,
    // so rd_valid trails the tick; the same edge is sampled whatever the clock ratio
    next_s.cap_dly = {s.cap_dly[0], 1'b0};
    if (s.cap_dly[1]) begin
      next_s.rdd = s.d_s2;
      next_s.rdv = 1'b1;
    end
    // the divided clock shares the counter, so both clocks stay phase aligned
    // full-rate clock is ref over 2; divided one takes the same bit at factor 1, a higher phase bit otherwise
    next_s.ph = s.ph + 1'b1;
    next_s.full_clk = next_s.ph[0];
    if (div_sel == ssp_pkg::DIV_BY_1) begin
      next_s.div_clk = next_s.ph[0];
    end else if (div_sel == ssp_pkg::DIV_BY_2) begin
      next_s.div_clk = next_s.ph[1];
    end else begin
      next_s.div_clk = next_s.ph[2];
    end
    // pins move on the same ref edge on which the chosen clock rises
    full_tick = next_s.full_clk & ~s.full_clk;
    div_tick = next_s.div_clk & ~s.div_clk;
    hd_tick = sel_tick(hd_cfg.clock_source_select, full_tick, div_tick);
    cur_tick = sel_tick(cur_cfg.clock_source_select, full_tick, div_tick);
    case (s.st)
      ssp_pkg::ST_IDLE: begin
        // an idle tick with nothing queued leaves all pins unchanged
        if (q_valid && hd_tick) begin
          next_s = issue(next_s, q_data, hd_cfg);
          q_pop = 1'b1;
        end
      end
      ssp_pkg::ST_ACC: begin
        if (cur_tick) begin
          // single-cycle command strobes end here
          next_s.pins.sa_n = 1'b1;
          next_s.pins.sc_n = 1'b1;
          if (!(cur_cfg.select_extend && !s.wr)) begin
            next_s.pins.cs_n = '1;
          end
          if (s.wr) begin
            if (s.pins.doe) begin
              next_s.pins.doe = 1'b0;
              done = 1'b1;
            end else if (s.cnt == '0) begin
              next_s.pins.doe = 1'b1;
            end else begin
              next_s.cnt = s.cnt - 1'b1;
            end
          end else if (s.cnt == '0) begin
            // mark the capture tick; data is taken once it has crossed both flops
            next_s.cap_dly[0] = 1'b1;
            next_s.pins.sb_n = 1'b1;
            next_s.pins.cs_n = '1;
            done = 1'b1;
          end else begin
            next_s.cnt = s.cnt - 1'b1;
          end
          if (done) begin
            next_s.st = ssp_pkg::ST_IDLE;
            // fifo mode chains the next access with no deselect gap
            if (cur_cfg.strobe_function_select && q_valid && hd_cfg.strobe_function_select
                && hd_cfg.clock_source_select == cur_cfg.clock_source_select) begin
              next_s = issue(next_s, q_data, hd_cfg);
              q_pop = 1'b1;
            end
            // otherwise idle gives at least one deselect cycle
          end
        end
      end
      default: begin
        next_s.st = ssp_pkg::ST_IDLE;
      end
    endcase
  end

  // synchronous reset parks every pin at its inactive level
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
      s.pins <= ssp_pkg::PINS_RST;
    end else begin
      s <= next_s;
    end
  end
endmodule : ssp_port

//--- tb/ssp_mem_model.sv
// partner: behavioural synchronous memory on the selected forwarded clock
`timescale 1ns/10ps
module ssp_mem_model (
  // forwarded clocks and settings
  input wire logic full_rate_mem_clock_out,
  input wire logic divided_mem_clock_out,
  input wire ssp_pkg::ssp_sec_s [ssp_pkg::SPACES-1:0] space_secondary_control,
  // command and data pins
  input wire logic [3:0] chip_select_n,
  input wire logic [19:0] address_bus_out,
  input wire logic [31:0] memory_data_bus_o,
  input wire logic memory_data_bus_oe,
  input wire logic shared_strobe_a_n,
  input wire logic shared_strobe_c_n,
  output logic [31:0] memory_data_bus_i
);
  logic [31:0] mem [16];
  logic rd = 1'b0;
  logic [3:0] ad = 4'h0;
  logic [1:0] lat = 2'h0;
  ssp_pkg::ssp_sec_s c;
  int cnt = 99;
  // all spaces share one clock source in this bench
  wire sclk = space_secondary_control[0].clock_source_select ? divided_mem_clock_out : full_rate_mem_clock_out;
  initial memory_data_bus_i = 32'h00000000;
  // pins read 1 ns after the edge, once settled; no race with the launching flops
  always @(posedge sclk) begin
    #1;
    memory_data_bus_i = ~memory_data_bus_i; // idle bus wanders, never a stale word
    if (!shared_strobe_a_n && chip_select_n != 4'hF) begin
      cnt = 0;
      rd = shared_strobe_c_n;
      ad = address_bus_out[3:0];
      for (int i = 0; i < 4; i++) if (!chip_select_n[i]) c = space_secondary_control[i];
      lat = rd ? c.read_latency_cycles : c.write_latency_cycles;
    end
    if (cnt == lat && rd) memory_data_bus_i = mem[ad];
    if (cnt == lat && !rd && memory_data_bus_oe) mem[ad] = memory_data_bus_o;
    cnt++;
  end
endmodule : ssp_mem_model

//--- tb/ssp_port_props.sv
// checker: pin timing relations of the synchronous memory port
`timescale 1ns/10ps
module ssp_port_chk (
  // clock, reset and settings
  input wire logic ref_clk,
  input wire logic rstn,
  input wire ssp_pkg::ssp_sec_s [ssp_pkg::SPACES-1:0] space_secondary_control,
  input wire logic [1:0] div_sel,
  // outputs watched
  input wire logic rd_valid,
  input wire logic full_rate_mem_clock_out,
  input wire logic divided_mem_clock_out,
  input wire logic [3:0] chip_select_n,
  input wire logic [3:0] byte_lane_enable_n,
  input wire logic [19:0] address_bus_out,
  input wire logic memory_data_bus_oe,
  input wire logic shared_strobe_a_n,
  input wire logic shared_strobe_b_n,
  input wire logic shared_strobe_c_n
);
  default clocking dck @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // forwarded clocks: full rate toggles every cycle, /2 setting has half period 2
  property p_full_clk; $past(rstn) |-> full_rate_mem_clock_out != $past(full_rate_mem_clock_out); endproperty
  a_full_clk: assert property (p_full_clk) else $error("full clock stalled");
  property p_div_clk; $rose(divided_mem_clock_out) && div_sel == 2'h1 && $past(div_sel, 4) == 2'h1 && $past(rstn, 4)
    |-> $past(divided_mem_clock_out, 2) == 1'b0 && $past(divided_mem_clock_out, 3) == 1'b1; endproperty
  a_div_clk: assert property (p_div_clk) else $error("divided clock period");
  // pins move only where a forwarded clock rises
  property p_pin_tick; $changed({chip_select_n, byte_lane_enable_n, address_bus_out, memory_data_bus_oe,
    shared_strobe_a_n, shared_strobe_b_n, shared_strobe_c_n}) |->
    $rose(full_rate_mem_clock_out) || $rose(divided_mem_clock_out); endproperty
  a_pin_tick: assert property (p_pin_tick) else $error("pin moved off tick");
  property p_wr_cmd; !shared_strobe_c_n |-> shared_strobe_b_n && !shared_strobe_a_n; endproperty
  a_wr_cmd: assert property (p_wr_cmd) else $error("write strobe roles");
  // bus drive never overlaps the memory output enable, and ends within one tick
  property p_bus_off; memory_data_bus_oe |-> shared_strobe_b_n; endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus contention");
  property p_oe_len; $rose(memory_data_bus_oe) |-> ##[2:8] (!memory_data_bus_oe || !shared_strobe_c_n); endproperty
  a_oe_len: assert property (p_oe_len) else $error("write data held long");
  // read data leaves the two-flop synchroniser two cycles after the capture tick
  property p_rd_pulse; $rose(shared_strobe_b_n) |-> ##2 rd_valid ##1 !rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("capture pulse");
  property p_ext_cs; $rose(shared_strobe_b_n) && shared_strobe_a_n |-> chip_select_n == 4'hF; endproperty
  a_ext_cs: assert property (p_ext_cs) else $error("select outlives enable");
  // mask picks the strobe-function bit of all four spaces
  property p_desel; $rose(shared_strobe_b_n) && !(|(space_secondary_control & 28'h0408102)) |-> shared_strobe_a_n;
  endproperty
  a_desel: assert property (p_desel) else $error("no deselect tick");
  // while a read waits for its data, no new command may move enables or address
  property p_be_hold; !shared_strobe_b_n && $past(!shared_strobe_b_n) && shared_strobe_a_n |->
    $stable(byte_lane_enable_n) && $stable(address_bus_out); endproperty
  a_be_hold: assert property (p_be_hold) else $error("enables moved mid-access");
  c_chain: cover property ($rose(shared_strobe_b_n) && !shared_strobe_a_n);
  c_ext: cover property ($rose(shared_strobe_b_n) && $past(chip_select_n) != 4'hF);
  c_wr: cover property ($rose(memory_data_bus_oe));
endmodule : ssp_port_chk

bind ssp_port ssp_port_chk u_ssp_port_chk (.ref_clk, .rstn, .space_secondary_control, .div_sel, .rd_valid,
  .full_rate_mem_clock_out, .divided_mem_clock_out, .chip_select_n, .byte_lane_enable_n, .address_bus_out,
  .memory_data_bus_oe, .shared_strobe_a_n, .shared_strobe_b_n, .shared_strobe_c_n);

//--- tb/tb_ssp_port.sv
// testbench: memory port against the behavioural memory
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %h", $time, g); end end
module tb_ssp_port;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  ssp_pkg::ssp_sec_s [ssp_pkg::SPACES-1:0] space_secondary_control = '0;
  logic [1:0] div_sel = 2'h1;
  logic req_valid = 1'b0;
  ssp_pkg::ssp_req_s req = '0;
  logic req_ready, rd_valid, full_rate_mem_clock_out, divided_mem_clock_out, memory_data_bus_oe;
  logic shared_strobe_a_n, shared_strobe_b_n, shared_strobe_c_n;
  logic [31:0] rd_data, memory_data_bus_o, memory_data_bus_i;
  logic [3:0] chip_select_n, byte_lane_enable_n;
  logic [19:0] address_bus_out;
  logic [31:0] m [16];
  logic [31:0] expq [$];
  int miscompares = 0, cmp_count = 0, cyc = 0, stalls = 0;
  ssp_port u_ssp_port (.ref_clk, .rstn, .space_secondary_control, .div_sel, .req_valid, .req_ready, .req, .rd_valid,
    .rd_data, .full_rate_mem_clock_out, .divided_mem_clock_out, .chip_select_n, .byte_lane_enable_n,
    .address_bus_out, .memory_data_bus_o, .memory_data_bus_oe, .memory_data_bus_i, .shared_strobe_a_n,
    .shared_strobe_b_n, .shared_strobe_c_n);
  ssp_mem_model u_ssp_mem_model (.full_rate_mem_clock_out, .divided_mem_clock_out, .space_secondary_control,
    .chip_select_n, .address_bus_out, .memory_data_bus_o, .memory_data_bus_oe, .memory_data_bus_i,
    .shared_strobe_a_n, .shared_strobe_c_n);
  initial forever #10 ref_clk = ~ref_clk;
  // each captured word against the oldest expectation
  always @(posedge ref_clk) if (rd_valid === 1'b1) `CHK(rd_data, expq.pop_front())
  // hang guard
  always @(posedge ref_clk) if (++cyc == 20000) begin miscompares++; print_verdict(); end
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // hold a request until the queue takes it; a full queue stalls us
  task automatic send(input logic w, input int k, input int s);
    req_valid <= 1'b1;
    req <= '{w, s[1:0], 4'(s), 20'(k), m[k]};
    @(posedge ref_clk);
    while (!req_ready) begin stalls++; @(posedge ref_clk); end
    if (!w) expq.push_back(m[k]);
  endtask : send
  // settings only change once the port has gone quiet
  task automatic settle(input int sh, input logic ext, input logic fn, input logic ck, input logic [1:0] dv);
    int q;
    q = 0;
    req_valid <= 1'b0;
    while (q < 80) begin
      @(posedge ref_clk);
      q = (chip_select_n == 4'hF && shared_strobe_b_n && expq.size() == 0) ? q + 1 : 0;
    end
    for (int i = 0; i < 4; i++) space_secondary_control[i] <= '{2'(i + sh), 2'(3 - i), ext & i[0], fn, ck};
    div_sel <= dv;
    @(posedge ref_clk);
  endtask : settle
  initial begin
    void'($urandom(52));
    for (int k = 0; k < 16; k++) m[k] = $urandom;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    // full clock writes, every space and write latency, queue overfilled
    settle(0, 0, 0, ssp_pkg::CLK_FULL, 2'h1);
    for (int k = 0; k < 16; k++) send(1, k, k);
    // full clock read back, read latency 0 to 3
    for (int k = 0; k < 4; k++) send(0, k, k);
    // divided clock read back, every read latency, odd spaces extended
    settle(1, 1, 0, ssp_pkg::CLK_DIV, 2'h1);
    `CHK(stalls > 0, 1'b1)
    for (int k = 0; k < 16; k++) send(0, k, k + 1);
    // read-enable mode, chained write then read, random spaces
    settle(2, 0, 1, ssp_pkg::CLK_DIV, 2'h2);
    for (int k = 0; k < 16; k++) begin
      m[k] = $urandom;
      send(1, k, $urandom);
      send(0, k, $urandom);
    end
    // divided clock at factor 1
    settle(0, 0, 0, ssp_pkg::CLK_DIV, 2'h0);
    for (int k = 4; k < 8; k++) send(0, k, k);
    settle(0, 0, 0, ssp_pkg::CLK_DIV, 2'h0);
    // second reset mid-run: pins released, queue open
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK({chip_select_n, req_ready, memory_data_bus_oe}, 6'h3E)
    print_verdict();
  end
endmodule : tb_ssp_port
